// ===== rtl/rfpg_regs.sv
/*
  Ripple fixup and PI gain configuration register bank with Avalon-MM slave.
  Assumes a single clock; outputs feed the ripple counter and PI loop.
*/
// Register access over Avalon-MM is this design's own decision.
// What this block does
// RL1 - Pulse stop 0: corrector always pulses; 1: may withhold pulses
// RL2 - Three-bit lowpass setting: larger means slower ripple counter response
// RL3 - Extra ripple window codes 0..3 map to 20, 30, 40, 50 percent
// RL4 - Missed ripple window codes 0..3 map to 20, 30, 40, 50 percent
// RL5 - Proportional divisor codes give 32,64,128,256,512,16,1
// RL6 - Effective proportional gain is numerator divided by selected divisor
// RL7 - Integral divisor codes give 32,64,128,256,512,16,1
// RL8 - Effective integral gain is numerator divided by selected divisor
// RL9 - Block off bit disables the whole corrector, independent of pulse stop
// RL10 - Count on enables ripple counting; fixup settings act only then
// RL11 - Software should not write divisor code 111
`timescale 1ns/1ps
module rfpg_regs
  import rfpg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_fixup_active,
  output logic o_fixup_pulse_allow_hold,
  output logic o_ripple_count_on,
  output logic [2:0] o_motion_lowpass_setting,
  output logic [5:0] o_extra_ripple_pct,
  output logic [5:0] o_missed_ripple_pct,
  output logic [13:0] o_prop_gain_q9,
  output logic [13:0] o_integ_gain_q9
);
  logic [7:0] filter_reg;
  logic [7:0] prop_reg;
  logic [7:0] integ_reg;
  logic [7:0] ctrl_reg;
  rfpg_state_t state_reg;
  logic [7:0] word_idx;
  logic [7:0] rd_mux;
  logic prop_res;
  logic integ_res;
  logic wr_take;

  // ****************************************
  // Bus handshake
  // ****************************************
  // One wait cycle so read data come from a register
  assign word_idx = i_address[9:2];
  // Write lands only in the accept cycle, so a held write cannot land twice
  assign wr_take = i_write && (state_reg == RFPG_DONE) && i_byteenable[0];

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      state_reg <= RFPG_IDLE;
    else
      case (state_reg)
        RFPG_IDLE: state_reg <= (i_read || i_write) ? RFPG_DONE : RFPG_IDLE;
        RFPG_DONE: state_reg <= RFPG_WAIT;
        RFPG_WAIT: state_reg <= RFPG_IDLE;
        default: state_reg <= RFPG_IDLE;
      endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_waitrequest <= 1'b1;
    else
      o_waitrequest <= !((state_reg == RFPG_IDLE) && (i_read || i_write));
  end

  always_comb
  begin
    case (word_idx)
      RFPG_IDX_FILTER: rd_mux = filter_reg;
      RFPG_IDX_PROP: rd_mux = prop_reg;
      RFPG_IDX_INTEG: rd_mux = integ_reg;
      RFPG_IDX_CTRL: rd_mux = ctrl_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_readdata <= 32'h00000000;
    else if (state_reg == RFPG_IDLE && i_read)
      o_readdata <= {24'h000000, rd_mux};
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      filter_reg <= RFPG_RST_FILTER;
      prop_reg <= RFPG_RST_PROP;
      integ_reg <= RFPG_RST_INTEG;
      ctrl_reg <= RFPG_RST_CTRL;
    end
    else if (wr_take)
      case (word_idx)
        RFPG_IDX_FILTER: filter_reg <= i_writedata[7:0];
        RFPG_IDX_PROP: prop_reg <= i_writedata[7:0];
        RFPG_IDX_INTEG: integ_reg <= i_writedata[7:0];
        RFPG_IDX_CTRL: ctrl_reg <= {6'h00, i_writedata[1:0]};
        default: ctrl_reg <= ctrl_reg;
      endcase
  end

  // ****************************************
  // Outputs to the corrector and PI loop
  // ****************************************
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_ripple_count_on <= 1'b0;
      o_fixup_active <= 1'b0;
      o_fixup_pulse_allow_hold <= 1'b0;
      o_motion_lowpass_setting <= 3'h0;
      o_extra_ripple_pct <= 6'h00;
      o_missed_ripple_pct <= 6'h00;
    end
    else
    begin
      o_ripple_count_on <= ctrl_reg[RFPG_BIT_COUNT_ON]; // RL10
      // Corrector runs only while counting and not switched off
      o_fixup_active <= ctrl_reg[RFPG_BIT_COUNT_ON] && !ctrl_reg[RFPG_BIT_BLOCK_OFF]; // RL9
      o_fixup_pulse_allow_hold <= filter_reg[RFPG_BIT_PULSE_STOP]; // RL1
      o_motion_lowpass_setting <= filter_reg[6:4]; // RL2
      o_extra_ripple_pct <= rfpg_window_pct(filter_reg[3:2]); // RL3
      o_missed_ripple_pct <= rfpg_window_pct(filter_reg[1:0]); // RL4
    end
  end

  // RL5 RL6
  rfpg_gain_calc u_prop
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_numerator(prop_reg[4:0]),
    .i_div_code(prop_reg[7:5]),
    .o_gain_q9(o_prop_gain_q9),
    .o_reserved(prop_res)
  );

  // RL7 RL8 RL11
  rfpg_gain_calc u_integ
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_numerator(integ_reg[4:0]),
    .i_div_code(integ_reg[7:5]),
    .o_gain_q9(o_integ_gain_q9),
    .o_reserved(integ_res)
  );

  // ****************************************
  // Checks
  // ****************************************
  AST_PULSE: assert property (@(posedge i_clk) disable iff (i_reset) // RL1
    o_fixup_pulse_allow_hold == $past(filter_reg[7])) else $error("pulse stop mismatch");
  AST_LOWPASS: assert property (@(posedge i_clk) disable iff (i_reset) // RL2
    $changed(filter_reg[6:4]) |=> o_motion_lowpass_setting == $past(filter_reg[6:4])) else $error("lowpass");
  AST_EXTRA: assert property (@(posedge i_clk) disable iff (i_reset) // RL3
    filter_reg[3:2] == 2'h3 |=> o_extra_ripple_pct == 6'd50) else $error("extra window");
  AST_MISS: assert property (@(posedge i_clk) disable iff (i_reset) // RL4
    filter_reg[1:0] == 2'h0 |=> o_missed_ripple_pct == 6'd20) else $error("missed window");
  AST_PDIV16: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
    prop_reg[7:5] == 3'h5 |=> o_prop_gain_q9 == 14'({$past(prop_reg[4:0]), 5'h00})) else $error("prop div16");
  AST_PGAIN1: assert property (@(posedge i_clk) disable iff (i_reset) // RL6
    prop_reg[7:5] == 3'h6 |=> o_prop_gain_q9 == 14'({$past(prop_reg[4:0]), 9'h000})) else $error("prop div1");
  AST_IDIV32: assert property (@(posedge i_clk) disable iff (i_reset) // RL7
    integ_reg[7:5] == 3'h0 |=> o_integ_gain_q9 == 14'({$past(integ_reg[4:0]), 4'h0})) else $error("integ div32");
  AST_IRES: assert property (@(posedge i_clk) disable iff (i_reset) // RL8
    integ_reg[7:5] == 3'h7 |=> integ_res && o_integ_gain_q9 == 14'h0000) else $error("integ reserved");
  AST_BLOCK: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
    ctrl_reg[1] |=> !o_fixup_active) else $error("block off ignored");
  AST_COUNT: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
    !ctrl_reg[0] |=> !o_ripple_count_on && !o_fixup_active) else $error("count off");
  AST_PDIV512: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
    prop_reg[7:5] == 3'h4 |=> o_prop_gain_q9 == 14'($past(prop_reg[4:0]))) else $error("prop div512");
  AST_PDIV32: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
    prop_reg[7:5] == 3'h0 |=> o_prop_gain_q9 == 14'({$past(prop_reg[4:0]), 4'h0})) else $error("prop div32");
  AST_PRES: assert property (@(posedge i_clk) disable iff (i_reset) // RL5
    prop_reg[7:5] == 3'h7 |=> prop_res && o_prop_gain_q9 == 14'h0000) else $error("prop reserved");
  AST_IDIV16: assert property (@(posedge i_clk) disable iff (i_reset) // RL7
    integ_reg[7:5] == 3'h5 |=> o_integ_gain_q9 == 14'({$past(integ_reg[4:0]), 5'h00})) else $error("integ div16");
  AST_IGAIN1: assert property (@(posedge i_clk) disable iff (i_reset) // RL8
    integ_reg[7:5] == 3'h6 |=> o_integ_gain_q9 == 14'({$past(integ_reg[4:0]), 9'h000})) else $error("integ div1");
  AST_EXTRA20: assert property (@(posedge i_clk) disable iff (i_reset) // RL3
    filter_reg[3:2] == 2'h0 |=> o_extra_ripple_pct == 6'd20) else $error("extra window low");
  AST_MISS50: assert property (@(posedge i_clk) disable iff (i_reset) // RL4
    filter_reg[1:0] == 2'h3 |=> o_missed_ripple_pct == 6'd50) else $error("missed window high");
  AST_ACT_COUNT: assert property (@(posedge i_clk) disable iff (i_reset) // RL10
    o_fixup_active |-> o_ripple_count_on) else $error("corrector active without counting");
  AST_INDEP: assert property (@(posedge i_clk) disable iff (i_reset) // RL9
    $changed(filter_reg[7]) && $stable(ctrl_reg) |=> $stable(o_fixup_active)) else $error("block off follows pulse stop");
  // Bus shape: waitrequest low for one cycle, upper read bits always zero
  AST_WAIT: assert property (@(posedge i_clk) disable iff (i_reset)
    ((i_read || i_write) && !o_waitrequest) |=> o_waitrequest [*2]) else $error("handshake");
  AST_WR_ACCEPT: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_take |-> !o_waitrequest) else $error("write outside accept cycle");
  AST_RD_UPPER: assert property (@(posedge i_clk) disable iff (i_reset)
    o_readdata[31:8] == 24'h000000) else $error("read upper bits");

  // Main scenarios
  COV_WRITE: cover property (@(posedge i_clk) disable iff (i_reset) wr_take);
  COV_READ: cover property (@(posedge i_clk) disable iff (i_reset) i_read && !o_waitrequest);
  COV_PRES: cover property (@(posedge i_clk) disable iff (i_reset) prop_res);
  COV_IRES: cover property (@(posedge i_clk) disable iff (i_reset) integ_res);
  COV_BLOCKOFF: cover property (@(posedge i_clk) disable iff (i_reset) ctrl_reg[1] && ctrl_reg[0]);
endmodule

// ===== pkg/rfpg_pkg.sv
/*
  Package for the ripple fixup and PI gain register bank: offsets, fields,
  reset values and decode helpers.
  Assumes a 32-bit Avalon-MM slave with word addressing derived from byte addresses.
*/
package rfpg_pkg;
  localparam logic [7:0] RFPG_IDX_FILTER = 8'h17;
  localparam logic [7:0] RFPG_IDX_PROP = 8'h18;
  localparam logic [7:0] RFPG_IDX_INTEG = 8'h19;
  localparam logic [7:0] RFPG_IDX_CTRL = 8'h1a;
  localparam logic [7:0] RFPG_RST_FILTER = 8'h45;
  localparam logic [7:0] RFPG_RST_PROP = 8'h21;
  localparam logic [7:0] RFPG_RST_INTEG = 8'h21;
  localparam logic [7:0] RFPG_RST_CTRL = 8'h01;
  localparam int RFPG_BIT_PULSE_STOP = 7;
  localparam int RFPG_BIT_COUNT_ON = 0;
  localparam int RFPG_BIT_BLOCK_OFF = 1;
  localparam logic [2:0] RFPG_DIV_RESERVED = 3'h7;
  localparam logic [1:0] RFPG_WAIT_CYCLES = 2'h1;

  typedef enum logic [1:0]
  {
    RFPG_IDLE = 2'b00,
    RFPG_WAIT = 2'b01,
    RFPG_DONE = 2'b10
  } rfpg_state_t;

  // Divisor code to log2 of divisor; reserved code gives 0xf
  function automatic logic [3:0] rfpg_div_shift(input logic [2:0] code);
    case (code)
      3'h0: rfpg_div_shift = 4'h5;
      3'h1: rfpg_div_shift = 4'h6;
      3'h2: rfpg_div_shift = 4'h7;
      3'h3: rfpg_div_shift = 4'h8;
      3'h4: rfpg_div_shift = 4'h9;
      3'h5: rfpg_div_shift = 4'h4;
      3'h6: rfpg_div_shift = 4'h0;
      default: rfpg_div_shift = 4'hf;
    endcase
  endfunction

  // Window code to percent
  function automatic logic [5:0] rfpg_window_pct(input logic [1:0] code);
    rfpg_window_pct = 6'(6'd20 + 6'd10 * code);
  endfunction
endpackage

// ===== rtl/rfpg_gain_calc.sv
/*
  Gain evaluation: turns numerator and divisor code into a Q5.9 effective gain.
  Assumes inputs come from registers on the same clock.
*/
`timescale 1ns/1ps
module rfpg_gain_calc
  import rfpg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_numerator,
  input wire logic [2:0] i_div_code,
  output logic [13:0] o_gain_q9,
  output logic o_reserved
);
  logic [3:0] shift;
  logic [13:0] scaled;

  // ****************************************
  // Effective gain = numerator / divisor, 9 fraction bits
  // ****************************************
  always_comb
  begin
    shift = rfpg_div_shift(i_div_code); // RL5 RL7
    scaled = 14'(({9'h000, i_numerator} << 9) >> shift); // RL6 RL8
  end

  // Reserved code yields a zero gain so the loop holds still
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_gain_q9 <= 14'h0000;
      o_reserved <= 1'b0;
    end
    else
    begin
      o_reserved <= (i_div_code == RFPG_DIV_RESERVED);
      o_gain_q9 <= (i_div_code == RFPG_DIV_RESERVED) ? 14'h0000 : scaled;
    end
  end
endmodule

// ===== verification/rfpg_tb.sv
/*
  Self-checking bench for the ripple fixup and PI gain register bank.
  Assumes the rfpg_pkg package and the rfpg_regs design; it is the only master on the Avalon port.
*/
`timescale 1ns/1ps
module testbench;
  import rfpg_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [9:0] i_address = '0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = '0;
  logic [3:0] i_byteenable = 4'hf;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_fixup_active, o_fixup_pulse_allow_hold, o_ripple_count_on;
  logic [2:0] o_motion_lowpass_setting;
  logic [5:0] o_extra_ripple_pct, o_missed_ripple_pct;
  logic [13:0] o_prop_gain_q9, o_integ_gain_q9;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] rs = 32'd93262;
  logic [31:0] q;
  logic [7:0] v;
  logic [4:0] num;

  rfpg_regs i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_fixup_active(o_fixup_active),
    .o_fixup_pulse_allow_hold(o_fixup_pulse_allow_hold), .o_ripple_count_on(o_ripple_count_on),
    .o_motion_lowpass_setting(o_motion_lowpass_setting), .o_extra_ripple_pct(o_extra_ripple_pct),
    .o_missed_ripple_pct(o_missed_ripple_pct), .o_prop_gain_q9(o_prop_gain_q9),
    .o_integ_gain_q9(o_integ_gain_q9));

  always #5 i_clk = ~i_clk;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Expected Q5.9 gain; reserved code has no divisor, so zero
  function automatic logic [13:0] exp_gain(input logic [4:0] n, input logic [2:0] c);
    int divs [7] = '{32, 64, 128, 256, 512, 16, 1};
    if (c == 3'h7)
      return 14'h0;
    return 14'((int'(n) * 512) / divs[c]);
  endfunction

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low; the limit only guards a hang
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_write <= w;
    i_read <= !w;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_waitrequest !== 1'b0 && n < 50);
    r = o_readdata;
    if (n >= 50)
      failures++;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    test_done();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    settle();
    chk("lowpass", 32'h4, o_motion_lowpass_setting);
    chk("extra", 32'd30, o_extra_ripple_pct);
    chk("missed", 32'd30, o_missed_ripple_pct);
    chk("pgain", exp_gain(5'h1, 3'h1), o_prop_gain_q9);
    chk("igain", exp_gain(5'h1, 3'h1), o_integ_gain_q9);
    chk("hold", 32'h0, o_fixup_pulse_allow_hold);
    xfer(1'b0, 10'h05c, 8'h0, q);
    chk("rst filter", 32'h45, q);
    xfer(1'b0, 10'h060, 8'h0, q);
    chk("rst prop", 32'h21, q);
    xfer(1'b0, 10'h064, 8'h0, q);
    chk("rst integ", 32'h21, q);
    // Every divisor code, reserved one included, with a full-scale numerator first
    for (int c = 0; c < 8; c++)
    begin
      num = (c == 0) ? 5'h1f : 5'(rnd());
      xfer(1'b1, 10'h060, {3'(c), num}, q);
      xfer(1'b1, 10'h064, {3'(c), ~num}, q);
      settle();
      chk("pgain", exp_gain(num, 3'(c)), o_prop_gain_q9);
      chk("igain", exp_gain(~num, 3'(c)), o_integ_gain_q9);
      xfer(1'b0, 10'h064, 8'h0, q);
      chk("integ rd", {24'h0, 3'(c), ~num}, q);
    end
    for (int j = 0; j < 4; j++)
    begin
      v = {4'(rnd()), 2'(j), 2'(3 - j)};
      xfer(1'b1, 10'h05c, v, q);
      settle();
      chk("hold", v[7], o_fixup_pulse_allow_hold);
      chk("lowpass", v[6:4], o_motion_lowpass_setting);
      chk("extra", 20 + 10 * j, o_extra_ripple_pct);
      chk("missed", 50 - 10 * j, o_missed_ripple_pct);
    end
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, 10'h068, 8'(k), q);
      settle();
      chk("count on", k & 1, o_ripple_count_on);
      chk("fixup act", (k == 1), o_fixup_active);
    end
    // Lane 0 off drops the write; unmapped space reads zero and ignores writes
    i_byteenable <= 4'he;
    xfer(1'b1, 10'h060, 8'hff, q);
    i_byteenable <= 4'hf;
    xfer(1'b1, 10'h3fc, 8'h5a, q);
    xfer(1'b0, 10'h060, 8'h0, q);
    chk("prop kept", {24'h0, 3'h7, num}, q);
    xfer(1'b0, 10'h3fc, 8'h0, q);
    chk("unmapped", 32'h0, q);
    // Reset in mid-run brings every register back to its reset value
    @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("wait rst", 32'h1, o_waitrequest);
    chk("act rst", 32'h0, o_fixup_active);
    @(posedge i_clk);
    i_reset <= 1'b0;
    settle();
    chk("wait idle", 32'h1, o_waitrequest);
    chk("count on", 32'h1, o_ripple_count_on);
    chk("fixup act", 32'h1, o_fixup_active);
    chk("pgain", exp_gain(5'h1, 3'h1), o_prop_gain_q9);
    xfer(1'b0, 10'h068, 8'h0, q);
    chk("rst ctrl", 32'h1, q);
    xfer(1'b0, 10'h05c, 8'h0, q);
    chk("rst filter", 32'h45, q);
    test_done();
  end
endmodule
